// ===== common/prom_cmd_pkg.sv
// constants, enums and carriers for the serial prom erase/write command handler
// Operation
// - codes 0x01-0x0F erase the matching 4K sector
// - codes 0x00, 0x10-0x1F reserved, go idle
// - code 0x20 or more erases whole chip
// - erase code is last host byte
// - sector without flash stops, goes idle
// - first sync 0x86 sets baud, echoed
// - second sync 0x79 echoed, silent on error
// - write code 0x30 echoed when accepted
// - command error sends code three times, idle
// - blank top area skips password check
// - bad password, or security on a write command, stops, goes idle
// - link error during password goes idle
// - overwrite flag 0x55 ok, 0xAA skipped
// - checksum high then low over memory
// - then wait for next command code
// - sector erase with 0xFFFA blank hangs forever
// - chip erase also clears security program
package prom_cmd_pkg;

  // protocol bytes
  localparam logic [7:0]  SYNC1_BYTE   = 8'h86;
  localparam logic [7:0]  SYNC2_BYTE   = 8'h79;
  localparam logic [7:0]  CMD_WRITE    = 8'h30;
  localparam logic [7:0]  CMD_ERASE    = 8'hF0;
  localparam logic [7:0]  ERR_FRAME    = 8'hA1;
  localparam logic [7:0]  ERR_UNKNOWN  = 8'hA3;
  localparam logic [7:0]  FLAG_OK      = 8'h55;
  localparam logic [7:0]  FLAG_OVER    = 8'hAA;
  localparam logic [7:0]  BLANK_BYTE   = 8'hFF;
  localparam logic [7:0]  CODE_CHIP    = 8'h20;
  localparam logic [7:0]  CODE_RES_LO  = 8'h10;
  localparam logic [7:0]  REC_EOF      = 8'h01;
  localparam logic [1:0]  ERR_REPEAT   = 2'h3;
  // flash map
  localparam logic [15:0] FLASH_LO     = 16'h1000;
  localparam logic [15:0] FLASH_HI     = 16'hFFFF;
  localparam int          SECTOR_SHIFT = 12;
  // byte counters
  localparam logic [2:0]  ADDR_LAST    = 3'h5;
  localparam logic [2:0]  HDR_LAST     = 3'h3;
  // serial framing
  localparam logic [3:0]  BIT_STOP     = 4'h8;
  localparam logic [3:0]  BIT_TX_LAST  = 4'h9;
  localparam logic [3:0]  BIT_MEASURE  = 4'hF;

  // command handler states, gray along the main path
  typedef enum logic [4:0] {
    ST_SYNC1  = 5'h00, ST_SYNC2 = 5'h01, ST_CMD   = 5'h03, ST_PWADR = 5'h02,
    ST_PWCHK  = 5'h06, ST_PWCNT = 5'h07, ST_PWSTR = 5'h05, ST_PWCMP = 5'h04,
    ST_HREC   = 5'h0C, ST_HDATA = 5'h0D, ST_HCHK  = 5'h0F, ST_HWR   = 5'h0E,
    ST_HCKS   = 5'h0A, ST_FLAG  = 5'h0B, ST_SUMRD = 5'h09, ST_SUMHI = 5'h08,
    ST_SUMLO  = 5'h18, ST_ERCODE = 5'h19, ST_ERWAIT = 5'h1B, ST_ERRTX = 5'h1A,
    ST_DEAD   = 5'h1E, ST_STUCK = 5'h1F
  } state_e;

  // flash operations
  typedef enum logic [1:0] {
    FL_READ = 2'h0, FL_WRITE = 2'h1, FL_SECTOR = 2'h2, FL_CHIP = 2'h3
  } flash_op_e;

  // erase area classes
  typedef enum logic [1:0] {
    ER_RESERVED = 2'h0, ER_SECTOR = 2'h1, ER_CHIP = 2'h2
  } erase_kind_e;

  // request toward the flash array
  typedef struct packed {
    flash_op_e   op;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } flash_req_s;

  // flash status levels
  typedef struct packed {
    logic area_blank;  // 0xFFE0..0xFFFF all blank
    logic fffa_blank;  // 0xFFFA holds blank
    logic security_en; // security program enabled
  } flash_stat_s;

endpackage

// ===== logic/prom_cmd.sv
// serial prom erase and write command handler with autobaud link
`timescale 1ns/10ps
module prom_cmd #(
  parameter int         DEPTH   = 2,     // tx buffer entries
  parameter int         BAUD_W  = 16,    // baud counter width
  parameter logic [3:0] SECT_LO = 4'h1,  // lowest sector with flash
  parameter logic [3:0] SECT_HI = 4'hF   // highest sector with flash
) (
  input  wire  logic                      mclk_i,
  input  wire  logic                      reset_i,
  input  wire  logic                      rxd_i,
  output logic                            txd_o,
  output prom_cmd_pkg::flash_req_s        flash_req_o,
  output logic                            flash_valid_o,
  input  wire  logic                      flash_done_i,
  input  wire  logic [7:0]                flash_rdata_i,
  input  wire  prom_cmd_pkg::flash_stat_s flash_stat_i,
  output logic                            halted_o
);
  import prom_cmd_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);

  // whole module state
  typedef struct packed {
    state_e                     st;
    logic                       rx_prev;   // last line level
    logic                       rx_busy;   // receiving a character
    logic                       rx_meas;   // autobaud pending
    logic [BAUD_W-1:0]          rx_cnt;
    logic [3:0]                 rx_bit;
    logic [7:0]                 rx_sh;
    logic                       rx_full;   // byte waiting
    logic                       rx_ferr;   // its stop bit was low
    logic [7:0]                 rx_byte;
    logic [BAUD_W-1:0]          baud;      // cycles per bit
    logic [DEPTH-1:0][7:0]      fifo;
    logic [PW-1:0]              f_wr;
    logic [PW-1:0]              f_rd;
    logic [PW:0]                f_cnt;
    logic                       tx_busy;
    logic [BAUD_W-1:0]          tx_cnt;
    logic [3:0]                 tx_bit;
    logic [9:0]                 tx_sh;
    logic                       txd;
    flash_req_s                 freq;
    logic                       fvalid;
    logic [2:0]                 idx;       // address or header byte
    logic [47:0]                pw_addr;   // count addr, compare addr
    logic [7:0]                 left;      // bytes still to handle
    logic [15:0]                ptr;       // password pointer
    logic [7:0]                 rec_type;
    logic [15:0]                rec_addr;
    logic [7:0]                 wbyte;
    logic                       ovr;       // overwrite seen
    logic [15:0]                sum;
    logic [15:0]                sum_addr;
    logic [1:0]                 err_left;
    logic [7:0]                 err_byte;
    logic                       is_erase;
    logic                       halted;
  } state_s;

  state_s q;
  state_s n;

  // address lies in the flash window
  function automatic logic in_flash(input logic [23:0] a);
    in_flash = (a[23:16] == 8'h00) && (a[15:0] >= FLASH_LO);
  endfunction

  // classify an erase area code
  function automatic erase_kind_e erase_kind(input logic [7:0] c);
    if (c >= CODE_CHIP)
      erase_kind = ER_CHIP;
    else if (c == 8'h00 || c >= CODE_RES_LO)
      erase_kind = ER_RESERVED;
    else
      erase_kind = ER_SECTOR;
  endfunction

  // next state of everything
  always_comb begin
    logic       take;      // consume received byte
    logic       push;      // write tx buffer
    logic [7:0] pbyte;
    logic       can_push;
    logic       adv;       // hex data byte finished
    logic       pw_done;   // password phase finished
    logic [7:0] b;
    n        = q;
    take     = 1'b0;
    push     = 1'b0;
    pbyte    = 8'h00;
    adv      = 1'b0;
    pw_done  = 1'b0;
    b        = q.rx_byte;
    can_push = (q.f_cnt != FULL_CNT);

    // flash handshake ends on done
    if (q.fvalid && flash_done_i) begin
      n.fvalid = 1'b0;
    end

    unique case (q.st)
      // first sync, echo at measured rate
      ST_SYNC1: if (q.rx_full && can_push) begin
        take = 1'b1;
        if (b == SYNC1_BYTE && !q.rx_ferr) begin
          push  = 1'b1;
          pbyte = SYNC1_BYTE;
          n.st  = ST_SYNC2;
        end else begin
          n.st = ST_DEAD;
        end
      end
      ST_SYNC2: if (q.rx_full && can_push) begin
        take = 1'b1;
        if (b == SYNC2_BYTE && !q.rx_ferr) begin
          push  = 1'b1;
          pbyte = SYNC2_BYTE;
          n.st  = ST_CMD;
        end else begin
          n.st = ST_DEAD;
        end
      end
      ST_CMD: if (q.rx_full && can_push) begin
        take       = 1'b1;
        n.idx      = 3'h0;
        n.ovr      = 1'b0;
        n.err_left = ERR_REPEAT;
        if (q.rx_ferr) begin
          n.err_byte = ERR_FRAME;
          n.st       = ST_ERRTX;
        end else if (b == CMD_WRITE || b == CMD_ERASE) begin
          push       = 1'b1;
          pbyte      = b;
          n.is_erase = (b == CMD_ERASE);
          n.st       = ST_PWADR;
        end else begin
          n.err_byte = ERR_UNKNOWN;
          n.st       = ST_ERRTX;
        end
      end
      // error byte three times then idle
      ST_ERRTX: if (can_push) begin
        push       = 1'b1;
        pbyte      = q.err_byte;
        n.err_left = q.err_left - 2'h1;
        if (q.err_left == 2'h1)
          n.st = ST_DEAD;
      end
      ST_PWADR: if (q.rx_full) begin
        take      = 1'b1;
        n.pw_addr = {q.pw_addr[39:0], b};
        n.idx     = q.idx + 3'h1;
        if (q.rx_ferr)
          n.st = ST_DEAD;
        else if (q.idx == ADDR_LAST)
          n.st = ST_PWCHK;
      end
      ST_PWCHK: begin
        if (!in_flash(q.pw_addr[47:24]) || !in_flash(q.pw_addr[23:0]))
          n.st = ST_DEAD;
        else if (!q.is_erase && flash_stat_i.security_en)
          n.st = ST_DEAD;
        // blank top area skips the string
        else if (flash_stat_i.area_blank)
          pw_done = 1'b1;
        else begin
          n.fvalid = 1'b1;
          n.freq   = '{op: FL_READ, addr: q.pw_addr[39:24], wdata: 8'h00};
          n.st     = ST_PWCNT;
        end
      end
      // password length from count address
      ST_PWCNT: if (q.fvalid && flash_done_i) begin
        n.left = flash_rdata_i;
        n.ptr  = q.pw_addr[15:0];
        n.st   = (flash_rdata_i == 8'h00) ? ST_DEAD : ST_PWSTR;
      end
      // password byte in, fetch stored one
      ST_PWSTR: if (q.rx_full) begin
        take    = 1'b1;
        n.wbyte = b;
        n.freq  = '{op: FL_READ, addr: q.ptr, wdata: 8'h00};
        if (q.rx_ferr) begin
          n.st = ST_DEAD;
        end else begin
          n.fvalid = 1'b1;
          n.st     = ST_PWCMP;
        end
      end
      ST_PWCMP: if (q.fvalid && flash_done_i) begin
        n.ptr  = q.ptr + 16'h0001;
        n.left = q.left - 8'h01;
        if (flash_rdata_i != q.wbyte)
          n.st = ST_DEAD;
        else if (q.left == 8'h01)
          pw_done = 1'b1;
        else
          n.st = ST_PWSTR;
      end
      ST_ERCODE: if (q.rx_full) begin
        take   = 1'b1;
        n.freq = '{op: FL_CHIP, addr: {b[3:0], 12'h000}, wdata: 8'h00};
        if (q.rx_ferr) begin
          n.st = ST_DEAD;
        end else begin
          unique case (erase_kind(b))
            ER_RESERVED: n.st = ST_DEAD;
            ER_SECTOR: begin
              n.freq.op = FL_SECTOR;
              if (b[3:0] < SECT_LO || b[3:0] > SECT_HI)
                n.st = ST_DEAD;
              else if (flash_stat_i.fffa_blank || flash_stat_i.security_en)
                n.st = ST_STUCK;
              else begin
                n.fvalid = 1'b1;
                n.st     = ST_ERWAIT;
              end
            end
            default: begin
              n.fvalid = 1'b1;
              n.st     = ST_ERWAIT;
            end
          endcase
        end
      end
      // erase finishes, then checksum pass
      ST_ERWAIT: if (q.fvalid && flash_done_i) begin
        n.sum      = 16'h0000;
        n.sum_addr = FLASH_LO;
        n.st       = ST_SUMRD;
      end
      ST_HREC: if (q.rx_full) begin
        take  = 1'b1;
        n.idx = q.idx + 3'h1;
        unique case (q.idx)
          3'h0:    n.left = b;
          3'h1:    n.rec_addr[15:8] = b;
          3'h2:    n.rec_addr[7:0] = b;
          default: n.rec_type = b;
        endcase
        if (q.rx_ferr)
          n.st = ST_DEAD;
        else if (q.idx == HDR_LAST)
          n.st = (b == REC_EOF || q.left == 8'h00) ? ST_HCKS : ST_HDATA;
      end
      // data byte in, read its target
      ST_HDATA: if (q.rx_full) begin
        take     = 1'b1;
        n.wbyte  = b;
        n.fvalid = 1'b1;
        n.freq   = '{op: FL_READ, addr: q.rec_addr, wdata: 8'h00};
        n.st     = ST_HCHK;
      end
      ST_HCHK: if (q.fvalid && flash_done_i) begin
        if (flash_rdata_i != BLANK_BYTE) begin
          n.ovr = 1'b1;
          adv   = 1'b1;
        end else begin
          // write waits a cycle so valid drops between requests
          n.freq = '{op: FL_WRITE, addr: q.rec_addr, wdata: q.wbyte};
          n.st   = ST_HWR;
        end
      end
      // raise the write, then wait for done
      ST_HWR: begin
        if (!q.fvalid)
          n.fvalid = 1'b1;
        else if (flash_done_i)
          adv = 1'b1;
      end
      // record check byte, end record closes data
      ST_HCKS: if (q.rx_full) begin
        take  = 1'b1;
        n.idx = 3'h0;
        n.st  = (q.rec_type == REC_EOF) ? ST_FLAG : ST_HREC;
      end
      ST_FLAG: if (can_push) begin
        push       = 1'b1;
        pbyte      = q.ovr ? FLAG_OVER : FLAG_OK;
        n.sum      = 16'h0000;
        n.sum_addr = FLASH_LO;
        n.st       = ST_SUMRD;
      end
      // sum whole flash as it now stands
      ST_SUMRD: begin
        if (!q.fvalid) begin
          n.fvalid = 1'b1;
          n.freq   = '{op: FL_READ, addr: q.sum_addr, wdata: 8'h00};
        end else if (flash_done_i) begin
          n.sum      = q.sum + {8'h00, flash_rdata_i};
          n.sum_addr = q.sum_addr + 16'h0001;
          if (q.sum_addr == FLASH_HI)
            n.st = ST_SUMHI;
        end
      end
      ST_SUMHI: if (can_push) begin
        push  = 1'b1;
        pbyte = q.sum[15:8];
        n.st  = ST_SUMLO;
      end
      ST_SUMLO: if (can_push) begin
        push  = 1'b1;
        pbyte = q.sum[7:0];
        n.st  = ST_CMD;
      end
      ST_DEAD:  n.st = ST_DEAD;
      ST_STUCK: n.st = ST_STUCK;
      default:  n.st = ST_DEAD;
    endcase

    // password phase over, pick the command's data phase
    if (pw_done) begin
      n.idx = 3'h0;
      n.st  = q.is_erase ? ST_ERCODE : ST_HREC;
    end
    // step to next data byte of the record
    if (adv) begin
      n.rec_addr = q.rec_addr + 16'h0001;
      n.left     = q.left - 8'h01;
      n.st       = (q.left == 8'h01) ? ST_HCKS : ST_HDATA;
    end
    n.halted = (n.st == ST_DEAD) || (n.st == ST_STUCK);

    // tx buffer and shifter, start, eight data, stop
    if (!q.tx_busy && q.f_cnt != '0) begin
      n.tx_sh   = {1'b1, q.fifo[q.f_rd], 1'b0};
      n.txd     = 1'b0;
      n.tx_busy = 1'b1;
      n.tx_bit  = 4'h0;
      n.tx_cnt  = q.baud - 1'b1;
      n.f_rd    = (q.f_rd == PW'(DEPTH - 1)) ? '0 : q.f_rd + 1'b1;
      n.f_cnt   = q.f_cnt - 1'b1;
    end else if (q.tx_busy) begin
      if (q.tx_cnt != '0)
        n.tx_cnt = q.tx_cnt - 1'b1;
      else if (q.tx_bit == BIT_TX_LAST)
        n.tx_busy = 1'b0;
      else begin
        n.tx_sh  = {1'b1, q.tx_sh[9:1]};
        n.txd    = q.tx_sh[1];
        n.tx_bit = q.tx_bit + 4'h1;
        n.tx_cnt = q.baud - 1'b1;
      end
    end
    if (push) begin
      n.fifo[q.f_wr] = pbyte;
      n.f_wr         = (q.f_wr == PW'(DEPTH - 1)) ? '0 : q.f_wr + 1'b1;
      n.f_cnt        = n.f_cnt + 1'b1;
    end

    // receiver; a new byte wins over a same-cycle take
    if (take)
      n.rx_full = 1'b0;
    n.rx_prev = rxd_i;
    if (!q.rx_busy) begin
      if (q.rx_prev && !rxd_i) begin
        n.rx_busy = 1'b1;
        n.rx_bit  = q.rx_meas ? BIT_MEASURE : 4'h0;
        n.rx_cnt  = q.rx_meas ? '0 : q.baud + (q.baud >> 1);
      end
    end else if (q.rx_bit == BIT_MEASURE) begin
      // start plus bit 0 low, two bit times
      n.rx_cnt = q.rx_cnt + 1'b1;
      if (rxd_i) begin
        n.baud    = (q.rx_cnt == '0) ? BAUD_W'(1) : (q.rx_cnt + 1'b1) >> 1;
        n.rx_cnt  = (q.rx_cnt + 1'b1) >> 2;
        n.rx_bit  = 4'h1;
        n.rx_sh   = 8'h00;
        n.rx_meas = 1'b0;
      end
    end else if (q.rx_cnt != '0) begin
      n.rx_cnt = q.rx_cnt - 1'b1;
    end else if (q.rx_bit != BIT_STOP) begin
      n.rx_sh[q.rx_bit[2:0]] = rxd_i;
      n.rx_bit               = q.rx_bit + 4'h1;
      n.rx_cnt               = q.baud - 1'b1;
    end else begin
      n.rx_busy = 1'b0;
      n.rx_full = 1'b1;
      n.rx_byte = q.rx_sh;
      n.rx_ferr = !rxd_i;
    end
  end

  // register the state, synchronous reset
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      q         <= '0;
      q.st      <= ST_SYNC1;
      q.rx_prev <= 1'b1;
      q.rx_meas <= 1'b1;
      q.txd     <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // outputs straight from flops
  assign txd_o         = q.txd;
  assign flash_req_o   = q.freq;
  assign flash_valid_o = q.fvalid;
  assign halted_o      = q.halted;

endmodule

// ===== sim/prom_cmd_props.sv
// concurrent checks on the command handler ports
`timescale 1ns/10ps
module prom_cmd_props #(
  parameter logic [3:0] SECT_LO = 4'h1,  // lowest sector with flash
  parameter logic [3:0] SECT_HI = 4'hF   // highest sector with flash
) (
  input wire logic                      mclk_i,
  input wire logic                      reset_i,
  input wire logic                      rxd_i,
  input wire logic                      txd_o,
  input wire prom_cmd_pkg::flash_req_s  flash_req_o,
  input wire logic                      flash_valid_o,
  input wire logic                      flash_done_i,
  input wire logic [7:0]                flash_rdata_i,
  input wire prom_cmd_pkg::flash_stat_s flash_stat_i,
  input wire logic                      halted_o
);
  import prom_cmd_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  // request still waiting for the array
  sequence s_req_wait;
    flash_valid_o && !flash_done_i;
  endsequence
  // request answered this cycle
  sequence s_req_done;
    flash_valid_o && flash_done_i;
  endsequence
  AST_VALID_HOLD: assert property (s_req_wait |=> flash_valid_o && $stable(flash_req_o)) else $error("request moved");
  AST_VALID_DROP: assert property (s_req_done |=> !flash_valid_o) else $error("request kept after done");
  AST_HALT_STAYS: assert property (halted_o |=> halted_o) else $error("left halt without reset");
  AST_HALT_NO_FLASH: assert property (halted_o |-> !flash_valid_o) else $error("flash used while halted");
  AST_SECTOR_ADDR: assert property (flash_valid_o && flash_req_o.op == FL_SECTOR |->
    flash_req_o.addr[11:0] == 12'h000 && flash_req_o.addr[15:12] >= SECT_LO && flash_req_o.addr[15:12] <= SECT_HI)
    else $error("bad sector address");
  AST_NO_SECTOR_STUCK: assert property (flash_valid_o && flash_req_o.op == FL_SECTOR |->
    !flash_stat_i.fffa_blank && !flash_stat_i.security_en) else $error("sector erase despite lock");
  AST_NO_WRITE_SECURE: assert property (flash_valid_o && flash_req_o.op == FL_WRITE |->
    !flash_stat_i.security_en) else $error("write while secured");
  AST_WRITE_ADDR: assert property (flash_valid_o && flash_req_o.op == FL_WRITE |->
    flash_req_o.addr >= FLASH_LO) else $error("write below flash");
endmodule

bind prom_cmd prom_cmd_props #(.SECT_LO(SECT_LO), .SECT_HI(SECT_HI)) u_props (
  .mclk_i(mclk_i), .reset_i(reset_i), .rxd_i(rxd_i), .txd_o(txd_o), .flash_req_o(flash_req_o),
  .flash_valid_o(flash_valid_o), .flash_done_i(flash_done_i), .flash_rdata_i(flash_rdata_i),
  .flash_stat_i(flash_stat_i), .halted_o(halted_o));

// ===== sim/flash_model.sv
// flash array model answering the command handler requests
`timescale 1ns/10ps
module flash_model (
  input  wire logic                     mclk_i,
  input  wire logic                     slow_i,
  input  wire prom_cmd_pkg::flash_req_s flash_req_i,
  input  wire logic                     flash_valid_i,
  output logic                          flash_done_o,
  output logic [7:0]                    flash_rdata_o
);
  import prom_cmd_pkg::*;
  logic [7:0] mem [0:65535];  // byte array, blank at start
  logic [1:0] age_q;          // cycles a request has waited
  initial begin
    for (int a = 0; a < 65536; a++)
      mem[a] = BLANK_BYTE;
    age_q = 2'h0;
  end
  // prompt answer, or third cycle when slow
  assign flash_done_o  = flash_valid_i && (!slow_i || age_q == 2'h2);
  // data only valid in the done cycle
  assign flash_rdata_o = flash_done_o ? mem[flash_req_i.addr] : ~mem[flash_req_i.addr];
  // array update on the done edge
  always @(posedge mclk_i) begin
    age_q <= (flash_valid_i && !flash_done_o) ? age_q + 2'h1 : 2'h0;
    if (flash_done_o) begin
      case (flash_req_i.op)
        FL_WRITE: mem[flash_req_i.addr] <= flash_req_i.wdata;
        FL_SECTOR: for (int i = 0; i < 4096; i++) mem[{flash_req_i.addr[15:12], i[11:0]}] <= BLANK_BYTE;
        FL_CHIP: for (int i = 0; i < 65536; i++) mem[i] <= BLANK_BYTE;
        default: ;
      endcase
    end
  end
endmodule

// ===== sim/serial_prom_erase_write_cmds_test.sv
// testbench for the erase and write command handler
`timescale 1ns/10ps
module serial_prom_erase_write_cmds_test;
  import prom_cmd_pkg::*;
  typedef logic [7:0] bq_t [$];
  localparam int BAUD = 8;        // cycles per bit
  logic          mclk_i;          // 25 MHz clock
  logic          reset_i;         // sync reset
  logic          rxd_i;           // host to device line
  logic          txd_o;           // device to host line
  logic          slow_q;          // slow flash answers
  flash_req_s    flash_req_o;     // array request
  logic          flash_valid_o;   // request pending
  logic          flash_done_i;    // array answer
  logic [7:0]    flash_rdata_i;   // array read data
  logic          halted_o;        // dead or stuck
  flash_stat_s   stat_q;          // array status levels
  bq_t           rx_q;            // bytes from device
  flash_req_s    erase_req;       // last erase request
  logic          erase_seen;      // an erase was issued
  int            err_count;
  int            n_tests;

  prom_cmd #(.SECT_HI(4'hE)) u_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .rxd_i(rxd_i), .txd_o(txd_o), .flash_req_o(flash_req_o),
    .flash_valid_o(flash_valid_o), .flash_done_i(flash_done_i), .flash_rdata_i(flash_rdata_i),
    .flash_stat_i(stat_q), .halted_o(halted_o));
  flash_model u_flash (
    .mclk_i(mclk_i), .slow_i(slow_q), .flash_req_i(flash_req_o), .flash_valid_i(flash_valid_o),
    .flash_done_o(flash_done_i), .flash_rdata_o(flash_rdata_i));

  // clock
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // receiver, samples mid bit on falling edges
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge mclk_i);
      if (txd_o === 1'b0 && reset_i === 1'b0) begin
        repeat (BAUD / 2) @(negedge mclk_i);
        for (int i = 0; i < 8; i++) begin
          repeat (BAUD) @(negedge mclk_i);
          b[i] = txd_o;
        end
        repeat (BAUD) @(negedge mclk_i);
        check(txd_o, 1'b1);
        rx_q.push_back(b);
      end
    end
  end

  // erase requests seen at the array
  always @(negedge mclk_i) begin
    if (flash_valid_o === 1'b1 && flash_req_o.op inside {FL_SECTOR, FL_CHIP}) begin
      erase_seen = 1'b1;
      erase_req = flash_req_o;
    end
  end

  task automatic do_reset();
    @(posedge mclk_i);
    reset_i <= 1'b1;
    rxd_i <= 1'b1;
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    rx_q.delete();
    erase_seen = 1'b0;
    @(posedge mclk_i);
    #1;
    check(halted_o, 1'b0);
  endtask

  // start, eight data lsb first, stop
  task automatic send_byte(input logic [7:0] b, input logic stop);
    logic [9:0] frame;
    frame = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk_i);
      rxd_i <= frame[i];
      repeat (BAUD - 1) @(posedge mclk_i);
    end
    @(posedge mclk_i);
    rxd_i <= 1'b1;
    repeat (2 * BAUD) @(posedge mclk_i);
  endtask

  // syncs, command, both addresses, no string
  function automatic bq_t head(input logic [7:0] cmd);
    return '{SYNC1_BYTE, SYNC2_BYTE, cmd, 8'h00, 8'h10, 8'h00, 8'h00, 8'h10, 8'h00};
  endfunction

  // one session from reset, byte bad sent with low stop bit
  task automatic run_seq(input bq_t seq, input int bad, input bq_t exp, input logic halt, input int span);
    do_reset();
    foreach (seq[i]) send_byte(seq[i], i != bad);
    repeat (span) @(posedge mclk_i);
    #1;
    check(rx_q.size(), exp.size());
    foreach (exp[i]) check(rx_q[i], exp[i]);
    check(halted_o, halt);
  endtask

  task automatic t_link_errors();
    @(posedge mclk_i);
    stat_q <= '{1'b1, 1'b0, 1'b0};
    run_seq({SYNC1_BYTE, SYNC2_BYTE, 8'h55}, -1, {SYNC1_BYTE, SYNC2_BYTE, ERR_UNKNOWN, ERR_UNKNOWN, ERR_UNKNOWN}, 1, 600);
    run_seq({SYNC1_BYTE, SYNC2_BYTE, CMD_WRITE}, 2, {SYNC1_BYTE, SYNC2_BYTE, ERR_FRAME, ERR_FRAME, ERR_FRAME}, 1, 600);
    run_seq({SYNC1_BYTE, 8'h78, CMD_WRITE}, -1, {SYNC1_BYTE}, 1, 300);
    run_seq(head(CMD_WRITE), 5, {SYNC1_BYTE, SYNC2_BYTE, CMD_WRITE}, 1, 300);
    run_seq({SYNC1_BYTE, SYNC2_BYTE, CMD_WRITE, 8'h00, 8'h00, 8'h10, 8'h00, 8'h10, 8'h00}, -1,
            {SYNC1_BYTE, SYNC2_BYTE, CMD_WRITE}, 1, 300);
    @(posedge mclk_i);
    stat_q <= '{1'b1, 1'b0, 1'b1};
    run_seq(head(CMD_WRITE), -1, {SYNC1_BYTE, SYNC2_BYTE, CMD_WRITE}, 1, 300);
  endtask

  task automatic t_erase_codes();
    logic [7:0] code [10] = '{8'h01, 8'h0E, 8'h0F, 8'h00, 8'h10, 8'h1F, 8'h20, 8'hFF, 8'h03, 8'h04};
    logic [1:0] op [10]   = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0};
    logic [1:0] st [10]   = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk_i);
      stat_q <= '{1'b1, st[i][1], st[i][0]};
      slow_q <= i[0];
      // code is the last host byte
      run_seq({head(CMD_ERASE), code[i]}, -1, {SYNC1_BYTE, SYNC2_BYTE, CMD_ERASE}, op[i] == 2'h0, 300);
      check(erase_seen, op[i] != 2'h0);
      if (op[i] != 2'h0) check(erase_req.op, op[i]);
      if (op[i] == 2'h2) check(erase_req.addr, {code[i][3:0], 12'h000});
    end
  endtask

  task automatic t_password();
    @(posedge mclk_i);
    stat_q <= '{1'b0, 1'b0, 1'b0};
    u_flash.mem[16'h1000] = 8'h02;
    u_flash.mem[16'h1001] = 8'h5A;
    for (int k = 0; k < 2; k++) begin
      run_seq({head(CMD_ERASE), 8'h02, 8'h5B - k[7:0], CODE_CHIP}, -1, {SYNC1_BYTE, SYNC2_BYTE, CMD_ERASE}, k == 0, 300);
      check(erase_seen, k == 1);
    end
  endtask

  task automatic t_write_image();
    bq_t seq;
    logic [15:0] sum;
    int w;
    @(posedge mclk_i);
    stat_q <= '{1'b1, 1'b0, 1'b0};
    slow_q <= 1'b0;
    u_flash.mem[16'h2000] = 8'h00;
    do_reset();
    // records below the top area, the second hits a used byte
    seq = {head(CMD_WRITE), 8'h02, 8'h10, 8'h00, 8'h00, 8'hAB, 8'hCD, 8'h00,
           8'h01, 8'h20, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFF};
    foreach (seq[i]) send_byte(seq[i], 1'b1);
    w = 0;
    while (rx_q.size() < 6 && w < 200000) begin
      @(posedge mclk_i);
      w++;
    end
    sum = 16'h0000;
    for (int a = 16'h1000; a <= 16'hFFFF; a++)
      sum = sum + ((a == 16'h1000) ? 8'hAB : (a == 16'h1001) ? 8'hCD : (a == 16'h2000) ? 8'h00 : 8'hFF);
    check(rx_q[2], CMD_WRITE);
    check(rx_q[3], FLAG_OVER);
    check({rx_q[4], rx_q[5]}, sum);
    check(u_flash.mem[16'h1001], 8'hCD);
    check(u_flash.mem[16'h2000], 8'h00);
    seq = head(CMD_ERASE);
    seq = seq[2:$];
    seq.push_back(CODE_CHIP);
    foreach (seq[i]) send_byte(seq[i], 1'b1);
    repeat (300) @(posedge mclk_i);
    check(rx_q.size(), 7);
    check(rx_q[6], CMD_ERASE);
    check(erase_seen, 1'b1);
    check(erase_req.op, FL_CHIP);
  endtask

  // main sequence
  initial begin
    reset_i = 1'b1;
    rxd_i = 1'b1;
    slow_q = 1'b0;
    stat_q = '{1'b1, 1'b0, 1'b0};
    err_count = 0;
    n_tests = 0;
    t_link_errors();
    t_erase_codes();
    t_password();
    t_write_image();
    tally_and_finish();
  end

  // watchdog
  initial begin
    repeat (200000) @(posedge mclk_i);
    err_count++;
    tally_and_finish();
  end
endmodule
